// *** mgc_pkg.sv ***
// Constants shared by the module management control block: register map,
// field positions, reset values and timing counts.
// Assumes a 100 MHz core clock and a 32-bit APB register port.
package mgc_pkg;

   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   localparam int CLK_MHZ          = 100;           // Core clock rate in MHz
   localparam int INIT_TIME_MS     = 2000;          // Longest initialisation time
   localparam int RESET_MIN_US     = 2;             // Least reset pulse width
   localparam int INIT_CYC         = INIT_TIME_MS * 1000 * CLK_MHZ;
   localparam int RESET_MIN_CYC    = RESET_MIN_US * CLK_MHZ;

   // ==========================================================================
   // Lanes and flag layout
   // ==========================================================================
   localparam int NUM_LANES        = 4;
   localparam int FLAG_W           = 2 * NUM_LANES + 1;
   localparam int LOS_LSB          = 0;
   localparam int FAULT_LSB        = NUM_LANES;
   localparam int READY_BIT        = 2 * NUM_LANES;

   // ==========================================================================
   // Register offsets (byte addresses)
   // ==========================================================================
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_FLAGS   = 8'h04;
   localparam logic [7:0] ADDR_MASK    = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_COND    = 8'h10;

   // ==========================================================================
   // Status and control fields, reset values
   // ==========================================================================
   localparam int STAT_NOT_READY   = 0;
   localparam int STAT_FUNCTIONAL  = 1;
   localparam int STAT_LOW_POWER   = 2;
   localparam int STAT_RESPOND     = 3;
   localparam int STAT_BUSY        = 4;
   localparam int STAT_IRQ         = 5;
   localparam int CTRL_PDOWN       = 0;
   localparam logic [FLAG_W-1:0] MASK_RESET = 9'h000;
   localparam logic              PDOWN_RESET = 1'b0;

   // Initialisation sequencing
   typedef enum {ST_HOLD, ST_INIT, ST_READY} mgc_state_t;

endpackage : mgc_pkg

// *** mgc_sync.sv ***
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/1ps
module mgc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : mgc_sync

// *** mgc_cycle_timer.sv ***
// Counts clock cycles while run is high; done rises once LIMIT is reached.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
module mgc_cycle_timer #(
   parameter int LIMIT = 1
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Control
   input  wire logic run_in,
   output logic      done_out
);
   logic [31:0] count;

   // Count up while running, hold at the limit, restart when stopped
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count    <= 32'h0;
         done_out <= 1'b0;
      end else if (!run_in) begin
         count    <= 32'h0;
         done_out <= 1'b0;
      end else if (count < 32'(LIMIT - 1)) begin
         count    <= count + 32'h1;
      end else begin
         done_out <= 1'b1;
      end
   end
endmodule : mgc_cycle_timer

// *** mgc_mgmt_ctrl.sv ***
// Management control and status timing of a pluggable optical module:
// initialisation, reset pin filter, low power, select gating, flags, mask
// and the attention output, with registers reached over APB.
// Assumes pins and the two-wire clock arrive asynchronously to CORE_CLK_IN.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module mgc_mgmt_ctrl
   import mgc_pkg::*;
#(
   parameter int INIT_CYCLES = mgc_pkg::INIT_CYC,
   parameter int RESET_CYCLES = mgc_pkg::RESET_MIN_CYC
) (
   // Clock and reset
   input  wire logic                          CORE_CLK_IN,
   input  wire logic                          ARST_N_IN,
   // APB slave
   input  wire logic                          PSEL_IN,
   input  wire logic                          PENABLE_IN,
   input  wire logic                          PWRITE_IN,
   input  wire logic [7:0]                    PADDR_IN,
   input  wire logic [31:0]                   PWDATA_IN,
   output logic      [31:0]                   PRDATA_OUT,
   output logic                               PREADY_OUT,
   output logic                               PSLVERR_OUT,
   // Sideband pins from the host
   input  wire logic                          MODULE_RESET_N_IN,
   input  wire logic                          BUS_SELECT_N_IN,
   input  wire logic                          LOW_POWER_REQUEST_IN,
   // Two-wire bus observation
   input  wire logic                          SCL_IN,
   input  wire logic                          SDA_IN,
   // Monitored conditions
   input  wire logic [mgc_pkg::NUM_LANES-1:0] RX_LOS_IN,
   input  wire logic [mgc_pkg::NUM_LANES-1:0] TX_FAULT_IN,
   // Outputs to host and module
   output logic                               ATTENTION_IRQ_N_OUT,
   output logic                               PRESENCE_N_OUT,
   output logic                               BUS_RESPOND_OUT,
   output logic                               LOW_POWER_OUT,
   output logic                               FUNCTIONAL_OUT
);

   // ==========================================================================
   // Synchronised inputs
   // ==========================================================================
   localparam int SYNC_W = 5 + 2 * NUM_LANES;

   logic [SYNC_W-1:0]    sync_vec;
   logic                 reset_pin_n;
   logic                 select_n;
   logic                 lp_request;
   logic                 scl;
   logic                 sda;
   logic [NUM_LANES-1:0] los_cond;
   logic [NUM_LANES-1:0] fault_cond;

   mgc_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (ARST_N_IN),
      .async_in ({MODULE_RESET_N_IN, BUS_SELECT_N_IN, LOW_POWER_REQUEST_IN,
                  SCL_IN, SDA_IN, RX_LOS_IN, TX_FAULT_IN}),
      .sync_out (sync_vec)
   );

   // Unpack the synchronised group
   assign {reset_pin_n, select_n, lp_request, scl, sda, los_cond, fault_cond} = sync_vec;

   // ==========================================================================
   // Reset pin filter and initialisation
   // ==========================================================================
   logic       reset_pulse_ok;
   logic       init_done;
   logic       reset_seen;
   mgc_state_t state;
   mgc_state_t next_state;

   // Reset pin must stay low for the least pulse time
   mgc_cycle_timer #(
      .LIMIT (RESET_CYCLES)
   ) u_reset_filter (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (ARST_N_IN),
      .run_in   (!reset_pin_n),
      .done_out (reset_pulse_ok)
   );

   // Initialisation runs for a bounded time after power or reset release
   mgc_cycle_timer #(
      .LIMIT (INIT_CYCLES)
   ) u_init_timer (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (ARST_N_IN),
      .run_in   (state == ST_INIT),
      .done_out (init_done)
   );

   // A valid reset pulse is latched until the pin rises again
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         reset_seen <= 1'b0;
      end else if (reset_pulse_ok) begin
         reset_seen <= 1'b1;
      end else if (reset_pin_n) begin
         reset_seen <= 1'b0;
      end
   end

   // Next state of the initialisation sequence
   always_comb begin
      next_state = state;
      case (state)
         ST_HOLD: begin
            if (reset_pin_n) begin
               next_state = ST_INIT;
            end
         end
         ST_INIT: begin
            if (reset_seen) begin
               next_state = ST_HOLD;
            end else if (init_done) begin
               next_state = ST_READY;
            end
         end
         ST_READY: begin
            if (reset_seen) begin
               next_state = ST_HOLD;
            end
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
   end

   // State register; power-up starts initialising at once
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state <= ST_INIT;
      end else begin
         state <= next_state;
      end
   end

   logic ready;
   logic in_reset;
   assign ready    = (state == ST_READY);
   assign in_reset = (state == ST_HOLD);

   // ==========================================================================
   // Two-wire bus observation: start, stop and commit point
   // ==========================================================================
   logic scl_d;
   logic sda_d;
   logic bus_busy;
   logic stop_seen;
   logic commit;
   logic respond;

   // Answer only when selected and initialised
   assign respond = ready && !select_n;

   // Previous levels for edge detection
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // Busy from start until the falling clock edge after the stop
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         bus_busy  <= 1'b0;
         stop_seen <= 1'b0;
      end else if (!respond) begin
         bus_busy  <= 1'b0;
         stop_seen <= 1'b0;
      end else if (scl && scl_d && sda_d && !sda) begin
         bus_busy  <= 1'b1;                            // Start; a pending stop still ends it
      end else if (scl && scl_d && !sda_d && sda && bus_busy) begin
         stop_seen <= 1'b1;                            // Stop
      end else if (stop_seen && scl_d && !scl) begin
         bus_busy  <= 1'b0;
         stop_seen <= 1'b0;
      end
   end

   // Staged effects apply whenever no transaction is open
   assign commit = !bus_busy;

   // ==========================================================================
   // APB slave
   // ==========================================================================
   logic              setup;
   logic              access;
   logic              addr_ok;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] mask;
   logic [FLAG_W-1:0] mask_active;
   logic              pdown;
   logic              pdown_active;
   logic [FLAG_W-1:0] clear_pending;
   logic [31:0]       status_word;
   logic              irq;

   assign setup  = PSEL_IN && !PENABLE_IN;
   assign access = PSEL_IN && PENABLE_IN;

   // Address decode of the mapped words
   always_comb begin
      if (PADDR_IN == ADDR_STATUS) begin
         addr_ok = 1'b1;
      end else if (PADDR_IN == ADDR_FLAGS) begin
         addr_ok = 1'b1;
      end else if (PADDR_IN == ADDR_MASK) begin
         addr_ok = 1'b1;
      end else if (PADDR_IN == ADDR_CONTROL) begin
         addr_ok = 1'b1;
      end else if (PADDR_IN == ADDR_COND) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // Zero wait states; unmapped addresses answer with an error
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = access && !addr_ok;

   // Status word seen by software
   always_comb begin
      status_word                  = 32'h0;
      status_word[STAT_NOT_READY]  = !ready;
      status_word[STAT_FUNCTIONAL] = FUNCTIONAL_OUT;
      status_word[STAT_LOW_POWER]  = LOW_POWER_OUT;
      status_word[STAT_RESPOND]    = respond;
      status_word[STAT_BUSY]       = bus_busy;
      status_word[STAT_IRQ]        = irq;
   end

   // Read data captured in the setup cycle, held through the access
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         PRDATA_OUT <= 32'h0;
      end else if (setup && !PWRITE_IN) begin
         if (PADDR_IN == ADDR_STATUS) begin
            PRDATA_OUT <= status_word;
         end else if (PADDR_IN == ADDR_FLAGS) begin
            PRDATA_OUT <= 32'(flags);
         end else if (PADDR_IN == ADDR_MASK) begin
            PRDATA_OUT <= 32'(mask);
         end else if (PADDR_IN == ADDR_CONTROL) begin
            PRDATA_OUT <= 32'(pdown);
         end else if (PADDR_IN == ADDR_COND) begin
            PRDATA_OUT <= 32'({fault_cond, los_cond});
         end else begin
            PRDATA_OUT <= 32'h0;
         end
      end
   end

   // Software mask and power-down bits
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         mask  <= MASK_RESET;
         pdown <= PDOWN_RESET;
      end else if (in_reset) begin
         mask  <= MASK_RESET;
         pdown <= PDOWN_RESET;
      end else if (access && PWRITE_IN) begin
         if (PADDR_IN == ADDR_MASK) begin
            mask  <= PWDATA_IN[FLAG_W-1:0];
         end else if (PADDR_IN == ADDR_CONTROL) begin
            pdown <= PWDATA_IN[CTRL_PDOWN];
         end
      end
   end

   // Written values take hold at the commit point
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         mask_active  <= MASK_RESET;
         pdown_active <= PDOWN_RESET;
      end else if (in_reset) begin
         mask_active  <= MASK_RESET;
         pdown_active <= PDOWN_RESET;
      end else if (commit) begin
         mask_active  <= mask;
         pdown_active <= pdown;
      end
   end

   // ==========================================================================
   // Flags: set by conditions, cleared by reading
   // ==========================================================================
   logic [NUM_LANES-1:0] los_d;
   logic [NUM_LANES-1:0] fault_d;
   logic                 ready_d;
   logic [FLAG_W-1:0]    flag_set;
   logic [FLAG_W-1:0]    read_clear;

   // Rising edges of each condition, and of readiness
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         los_d   <= '0;
         fault_d <= '0;
         ready_d <= 1'b0;
      end else begin
         los_d   <= los_cond;
         fault_d <= fault_cond;
         ready_d <= ready;
      end
   end

   // Only bits actually returned to software are cleared by the read
   assign read_clear = (access && !PWRITE_IN && PADDR_IN == ADDR_FLAGS) ?
                       PRDATA_OUT[FLAG_W-1:0] : '0;

   // Flag events are taken only once initialised, data-ready on entry
   always_comb begin
      flag_set = '0;
      if (ready) begin
         flag_set[LOS_LSB +: NUM_LANES]   = los_cond & ~los_d;
         flag_set[FAULT_LSB +: NUM_LANES] = fault_cond & ~fault_d;
      end
      flag_set[READY_BIT] = ready && !ready_d;
   end

   // Reads awaiting the commit point
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         clear_pending <= '0;
      end else if (in_reset || commit) begin
         clear_pending <= commit ? '0 : '0;
      end else begin
         clear_pending <= clear_pending | read_clear;
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         flags <= '0;
      end else if (in_reset) begin
         flags <= '0;
      end else if (commit) begin
         flags <= (flags & ~(clear_pending | read_clear)) | flag_set;
      end else begin
         flags <= flags | flag_set;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   // Attention while any unmasked flag stays set
   assign irq = |(flags & ~mask_active);

   // Registered pin levels
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ATTENTION_IRQ_N_OUT <= 1'b1;
         PRESENCE_N_OUT      <= 1'b0;
         BUS_RESPOND_OUT     <= 1'b0;
         LOW_POWER_OUT       <= 1'b0;
         FUNCTIONAL_OUT      <= 1'b0;
      end else begin
         ATTENTION_IRQ_N_OUT <= !irq;
         PRESENCE_N_OUT      <= 1'b0;                  // Module always present
         BUS_RESPOND_OUT     <= respond;
         LOW_POWER_OUT       <= lp_request || pdown_active;
         FUNCTIONAL_OUT      <= ready && (flags[READY_BIT] || ready_d);
      end
   end

endmodule : mgc_mgmt_ctrl

// *** mgc_ctrl_properties.sv ***
// Concurrent checks on the management control block, seen from its ports.
// Assumes one core clock domain and the asynchronous active-low core reset.
`timescale 1ns/1ps
module mgc_ctrl_properties #(
   parameter int INIT_CYCLES  = 50,
   parameter int RESET_CYCLES = 200
) (
   input wire logic       CORE_CLK_IN,
   input wire logic       ARST_N_IN,
   input wire logic       PSEL_IN,
   input wire logic       PENABLE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic       PREADY_OUT,
   input wire logic       PSLVERR_OUT,
   input wire logic       MODULE_RESET_N_IN,
   input wire logic       BUS_SELECT_N_IN,
   input wire logic       LOW_POWER_REQUEST_IN,
   input wire logic       ATTENTION_IRQ_N_OUT,
   input wire logic       BUS_RESPOND_OUT,
   input wire logic       LOW_POWER_OUT,
   input wire logic       FUNCTIONAL_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   int low_cnt;
   int up_cnt;
   // ==========================================================================
   // Helper counters
   // ==========================================================================
   // Consecutive low cycles of the pin reset, saturating
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) low_cnt <= 0;
      else if (MODULE_RESET_N_IN) low_cnt <= 0;
      else if (low_cnt < 100000) low_cnt <= low_cnt + 1;
   end
   // Cycles since core reset release or a pin reset that took hold
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) up_cnt <= 0;
      else if (low_cnt >= RESET_CYCLES + 4) up_cnt <= 0;
      else if (up_cnt < INIT_CYCLES + 100) up_cnt <= up_cnt + 1;
   end
   // ==========================================================================
   // Assertions
   // ==========================================================================
   init_early_a: assert property (up_cnt < INIT_CYCLES - 1 |-> !FUNCTIONAL_OUT && ATTENTION_IRQ_N_OUT)
      else $error("functional or attention during initialisation");
   respond_gate_a: assert property (up_cnt < INIT_CYCLES - 1 |-> !BUS_RESPOND_OUT)
      else $error("bus answered during initialisation");
   init_late_a: assert property (up_cnt == INIT_CYCLES + 8 |-> FUNCTIONAL_OUT)
      else $error("not functional after initialisation time");
   irq_ready_a: assert property ($rose(FUNCTIONAL_OUT) && up_cnt < INIT_CYCLES + 20
      |-> ##[0:2] !ATTENTION_IRQ_N_OUT)
      else $error("attention missing at ready");
   pin_reset_a: assert property (low_cnt == RESET_CYCLES + 6 |-> !FUNCTIONAL_OUT && !BUS_RESPOND_OUT)
      else $error("long pin reset not taken");
   select_on_a: assert property ((!BUS_SELECT_N_IN && FUNCTIONAL_OUT && MODULE_RESET_N_IN)[*4]
      |-> BUS_RESPOND_OUT)
      else $error("selected module not answering");
   select_off_a: assert property (BUS_SELECT_N_IN[*4] |-> !BUS_RESPOND_OUT)
      else $error("deselected module still answering");
   lp_enter_a: assert property (LOW_POWER_REQUEST_IN[*4] |-> LOW_POWER_OUT)
      else $error("low power request not followed");
   slverr_a: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 8'h10 |-> PSLVERR_OUT && PREADY_OUT)
      else $error("unmapped access not refused");
   cover property (low_cnt == RESET_CYCLES + 6);
   cover property ($rose(BUS_RESPOND_OUT));
   cover property ($rose(LOW_POWER_OUT));
endmodule : mgc_ctrl_properties

bind mgc_mgmt_ctrl mgc_ctrl_properties #(.INIT_CYCLES(INIT_CYCLES), .RESET_CYCLES(RESET_CYCLES))
   u_props (.CORE_CLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT,
   .MODULE_RESET_N_IN, .BUS_SELECT_N_IN, .LOW_POWER_REQUEST_IN, .ATTENTION_IRQ_N_OUT,
   .BUS_RESPOND_OUT, .LOW_POWER_OUT, .FUNCTIONAL_OUT);

// *** mgc_host_model.sv ***
// Host side of the two-wire bus: frames of START, nine clocks and STOP.
// Assumes pulled-up lines; the clock stands high between frames.
`timescale 1ns/1ps
module mgc_host_model (
   input  wire logic go_in,
   input  wire logic hold_in,
   output logic      scl_out,
   output logic      sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // One frame per go pulse; hold keeps it open before the STOP
   always @(posedge go_in) begin
      sda_out = 1'b0;
      #80;
      for (int i = 0; i < 9; i++) begin
         scl_out = 1'b0;
         #40 sda_out = i[0];
         #40 scl_out = 1'b1;
         #80;
      end
      wait (!hold_in);
      scl_out = 1'b0;
      #40 sda_out = 1'b0;
      #40 scl_out = 1'b1;
      #80 sda_out = 1'b1; // STOP, the timing reference point
   end
endmodule : mgc_host_model

// *** tb.sv ***
// Self-checking bench for the management control block.
// Assumes a 100 MHz core clock and a shortened initialisation count.
`timescale 1ns/1ps
module tb;
   import mgc_pkg::*;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} mgc_row_t;
   localparam int INIT_SIM = 50;
   logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, rst_pin_n = 1, sel_n = 1, lp_req = 0;
   logic go = 0, hold = 0, scl, sda, pready, pslverr, irq_n, pres_n, resp, lpo, func, er;
   logic [7:0] paddr = 8'h00, cond = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int err_total = 0, check_count = 0;
   mgc_row_t rows [10];
   // ==========================================================================
   // Clock, design and host
   // ==========================================================================
   always #5 clk = ~clk;
   mgc_mgmt_ctrl #(.INIT_CYCLES(INIT_SIM), .RESET_CYCLES(200)) DUT (
      .CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MODULE_RESET_N_IN(rst_pin_n),
      .BUS_SELECT_N_IN(sel_n), .LOW_POWER_REQUEST_IN(lp_req), .SCL_IN(scl), .SDA_IN(sda),
      .RX_LOS_IN(cond[3:0]), .TX_FAULT_IN(cond[7:4]), .ATTENTION_IRQ_N_OUT(irq_n),
      .PRESENCE_N_OUT(pres_n), .BUS_RESPOND_OUT(resp), .LOW_POWER_OUT(lpo), .FUNCTIONAL_OUT(func));
   mgc_host_model u_host (.go_in(go), .hold_in(hold), .scl_out(scl), .sda_out(sda));
   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic end_sim;
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   function automatic logic sig(input int k);
      case (k)
         0: return irq_n;
         1: return func;
         2: return resp;
         default: return lpo;
      endcase
   endfunction : sig
   // Bounded wait for an output level, then compare it
   task automatic wt(input int k, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(k) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk($sformatf("out%0d", k), 32'(v), 32'(sig(k)));
      if (n >= lim) end_sim;
   endtask : wt
   // One APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 50) begin
         chk("pready", 32'h1, 32'(pready));
         end_sim;
      end
   endtask : apb
   // ==========================================================================
   // Sequence
   // ==========================================================================
   initial begin
      rows = '{'{0, ADDR_MASK, 0, 0, 0}, '{0, ADDR_CONTROL, 0, 0, 0}, '{0, ADDR_FLAGS, 0, 32'h100, 0},
         '{0, ADDR_FLAGS, 0, 0, 0}, '{1, ADDR_MASK, 32'hffff_ffff, 0, 0}, '{0, ADDR_MASK, 0, 32'h1ff, 0},
         '{1, ADDR_MASK, 0, 0, 0}, '{0, ADDR_COND, 0, 0, 0}, '{0, 8'h20, 0, 0, 1}, '{1, 8'h20, 1, 0, 1}};
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      apb(0, ADDR_STATUS, 0);
      chk("not_ready", 32'h1, 32'(rd[STAT_NOT_READY]));
      chk("presence", 32'h0, 32'(pres_n));
      wt(1, 1, INIT_SIM + 20);
      chk("irq_ready", 32'h0, 32'(irq_n));
      apb(0, ADDR_STATUS, 0);
      chk("ready_bit", 32'h0, 32'(rd[STAT_NOT_READY]));
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("rdata", rows[i].e, rd);
         chk("slverr", 32'(rows[i].er), 32'(er));
      end
      wt(0, 1, 10);
      // Every lane condition raises, reads back and releases attention
      for (int i = 0; i < 8; i++) begin
         cond <= 8'h1 << i;
         wt(0, 0, 20);
         apb(0, ADDR_FLAGS, 0);
         chk("flag", 32'h1 << i, rd);
         wt(0, 1, 10);
         cond <= 8'h00;
         @(posedge clk);
      end
      apb(1, ADDR_MASK, 32'h1);
      cond <= 8'h01;
      repeat (10) @(posedge clk);
      chk("irq_masked", 32'h1, 32'(irq_n));
      apb(1, ADDR_MASK, 0);
      wt(0, 0, 10);
      apb(0, ADDR_FLAGS, 0);
      wt(0, 1, 10);
      cond <= 8'h00;
      sel_n <= 1'b0;
      wt(2, 1, 10);
      // Mask written while a two-wire frame is open waits for the first clock fall after the STOP
      hold <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (200) @(posedge clk);
      apb(1, ADDR_MASK, 32'h1);
      cond <= 8'h01;
      repeat (10) @(posedge clk);
      chk("irq_staged", 32'h0, 32'(irq_n));
      hold <= 1'b0;
      repeat (30) @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wt(0, 1, 40);
      sel_n <= 1'b1;
      wt(2, 0, 10);
      apb(1, ADDR_MASK, 0);
      wt(0, 0, 10);
      apb(0, ADDR_FLAGS, 0);
      wt(0, 1, 10);
      lp_req <= 1'b1;
      wt(3, 1, 10);
      lp_req <= 1'b0;
      wt(3, 0, 10);
      apb(1, ADDR_CONTROL, 32'h1);
      wt(3, 1, 10);
      apb(1, ADDR_CONTROL, 0);
      wt(3, 0, 10);
      wt(1, 1, 10);
      // Short pin pulse is ignored, long one reinitialises
      rst_pin_n <= 1'b0;
      repeat (100) @(posedge clk);
      rst_pin_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk("short_pulse", 32'h1, 32'(func));
      rst_pin_n <= 1'b0;
      repeat (400) @(posedge clk);
      chk("long_pulse", 32'h0, 32'(func));
      rst_pin_n <= 1'b1;
      wt(1, 1, INIT_SIM + 20);
      chk("irq_reinit", 32'h0, 32'(irq_n));
      end_sim;
   end
endmodule : tb
